// ### inc/tjl_pkg.sv
// ****************************************************************
// Overview of operation
// ****************************************************************
// Overview of operation
// - On T1/J1 entry load address compares high FD, FF and low FF, FF.
// - After reset all six global clock-mode registers hold 00.
// - After reset all receive/transmit/extra slot-select registers hold 00.
// - Line-standard bit low means E1 mode; host keeps it high for T1/J1.
// - In T1/J1, Japanese-variant bit 1 selects J1, 0 selects T1.
// - Control registers read/write, except the write-only command register.
// - Detect count 0A declares loss of signal after 176 zeros.
// - Recover count 15 clears loss after 22 ones in detection interval.
// - With density check on, recovery also needs no 15-zero run.
// - Status-change bit adds recovery interrupts beside activation ones.
// - Analog: AMI, AMI bit-7, B8ZS; digital adds precoded B8ZS and NRZ.
// - Reset input held at least 10 us resets; clock keeps running.
// - Comes up E1; T1/J1 defaults apply after 20 us settling.
package tjl_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_US = 10;
    localparam int SETTLE_MAX_US = 20;
    localparam int RST_CYC =
        (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = SETTLE_MAX_US * 1000 / CLK_PERIOD_NS;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADR_CFG = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h01;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h02;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h03;
    localparam logic [7:0] ADR_LOS_DET = 8'h04;
    localparam logic [7:0] ADR_LOS_RCV = 8'h05;
    localparam logic [7:0] ADR_CMD = 8'h06;
    localparam logic [7:0] ADR_BANK = 8'h08;
    localparam int BANK_N = 23;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CFG_STD = 0;
    localparam int CFG_JPN = 1;
    localparam int CFG_PDC = 2;
    localparam int CFG_SCI = 3;
    localparam int CFG_CODE = 4;
    localparam int CFG_DIG = 6;
    localparam int CFG_PRE = 7;
    localparam int ST_LOS = 0;
    localparam int ST_T1J1 = 1;
    localparam int ST_J1 = 2;
    localparam int ST_CODE_OK = 3;
    localparam int IRQ_W = 3;
    localparam int IRQ_LOS = 0;
    localparam int IRQ_RCV = 1;
    localparam int IRQ_SETTLE = 2;
    localparam int CMD_LOS_RESTART = 0;
    localparam logic [1:0] CODE_NRZ = 2'h0;
    localparam logic [1:0] CODE_B8ZS = 2'h3;

    // ************************************************************
    // reset values and loss-of-signal constants
    // ************************************************************
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] ADDR_HIGH1_RST = 8'hfd;
    localparam logic [7:0] ADDR_FF_RST = 8'hff;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
    localparam int BK_ADDR_HIGH1 = 3;
    localparam int BK_ADDR_LOW2 = 6;
    localparam int CNT_W = 13;
    localparam int DET_SHIFT = 4;
    localparam logic [CNT_W-1:0] DENS_RUN = 13'h000f;

    typedef enum logic [1:0] {
        MODE_E1 = 2'b00,
        MODE_SETTLE = 2'b01,
        MODE_T1J1 = 2'b11
    } tjl_mode_type;

    // mode, address compare, clock-mode and slot-select defaults
    function automatic logic [7:0] bank_default(input int idx);
        logic [7:0] v;
        v = REG_RST;
        if (idx == BK_ADDR_HIGH1) begin
            v = ADDR_HIGH1_RST;
        end else if (idx > BK_ADDR_HIGH1 && idx <= BK_ADDR_LOW2) begin
            v = ADDR_FF_RST;
        end
        return v;
    endfunction
endpackage

// ### hdl/tjl_counter.sv
`timescale 1ns/1ns
module tjl_counter #(
    parameter int W = 13
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_inc,
    // count
    output logic [W-1:0] o_cnt
);
    generate
        if (W < 1) begin : g_chk
            $error("counter width must be positive");
        end
    endgenerate

    // saturates so a long run never wraps back under a threshold
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_clr) begin
                o_cnt <= '0;
            end else if (i_inc && o_cnt != {W{1'b1}}) begin
                o_cnt <= o_cnt + W'(1);
            end
        end
    end
endmodule

// ### hdl/tjl_config_bank.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module tjl_config_bank
    import tjl_pkg::*;
#(
    parameter int AW = 8
) (
    // clock, enable, reset
    input wire logic I_CLK_SYS,
    input wire logic I_CE,
    input wire logic I_SRST,
    // register port
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // received line bits
    input wire logic I_RX_VALID,
    input wire logic I_RX_BIT,
    // status
    output logic O_LOS,
    output logic O_T1J1_MODE,
    output logic O_J1_MODE,
    output logic O_IRQ
);
    generate
        if (AW < 8) begin : g_chk
            $error("address width must be at least 8");
        end
    endgenerate

    localparam int BK_IW = $clog2(BANK_N);
    localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYC - 1);
    localparam logic [9:0] RST_LAST = 10'(RST_CYC - 1);

    // ************************************************************
    // reset qualification
    // ************************************************************
    logic [9:0] rst_cnt;
    logic rst;

    // short glitches on the reset input are ignored
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (!I_SRST) begin
                rst_cnt <= '0;
            end else if (rst_cnt != RST_LAST) begin
                rst_cnt <= rst_cnt + 10'(1);
            end
        end
    end
    assign rst = I_SRST && rst_cnt == RST_LAST;

    // ************************************************************
    // address decode
    // ************************************************************
    logic hit_cfg, hit_stat, hit_ist, hit_msk, hit_det, hit_rcv;
    logic hit_cmd, hit_bank;
    logic [AW-1:0] bank_off;
    logic [BK_IW-1:0] bank_idx;

    assign hit_cfg = I_ADDR == AW'(ADR_CFG);
    assign hit_stat = I_ADDR == AW'(ADR_STAT);
    assign hit_ist = I_ADDR == AW'(ADR_IRQ_STAT);
    assign hit_msk = I_ADDR == AW'(ADR_IRQ_MASK);
    assign hit_det = I_ADDR == AW'(ADR_LOS_DET);
    assign hit_rcv = I_ADDR == AW'(ADR_LOS_RCV);
    assign hit_cmd = I_ADDR == AW'(ADR_CMD);
    assign bank_off = I_ADDR - AW'(ADR_BANK);
    assign hit_bank = I_ADDR >= AW'(ADR_BANK) && bank_off < AW'(BANK_N);
    assign bank_idx = bank_off[BK_IW-1:0];

    // ************************************************************
    // control registers
    // ************************************************************
    logic [7:0] cfg, los_det, los_rcv;
    logic [IRQ_W-1:0] irq_stat, irq_mask;
    logic [7:0] bank [BANK_N];
    logic cmd_restart;
    logic load_dflt;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (rst) begin
                cfg <= REG_RST;
                los_det <= REG_RST;
                los_rcv <= REG_RST;
                irq_mask <= MASK_RST;
            end else if (I_WR) begin
                if (hit_cfg) begin
                    cfg <= I_WDATA;
                end
                if (hit_det) begin
                    los_det <= I_WDATA;
                end
                if (hit_rcv) begin
                    los_rcv <= I_WDATA;
                end
                if (hit_msk) begin
                    irq_mask <= I_WDATA[IRQ_W-1:0];
                end
            end
        end
    end

    // command is write-only: it leaves a one-cycle pulse, nothing stored
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            cmd_restart <= !rst && I_WR && hit_cmd
                && I_WDATA[CMD_LOS_RESTART];
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            for (int i = 0; i < BANK_N; i++) begin
                if (rst || load_dflt) begin
                    bank[i] <= bank_default(i);
                end else if (I_WR && hit_bank && bank_idx == BK_IW'(i)) begin
                    bank[i] <= I_WDATA;
                end
            end
        end
    end

    // ************************************************************
    // line standard selection
    // ************************************************************
    tjl_mode_type mode, next_mode;
    logic [9:0] settle_cnt;
    logic std_sel, settle_done;

    assign std_sel = cfg[CFG_STD];
    assign settle_done = mode == MODE_SETTLE && settle_cnt == SETTLE_LAST;
    assign load_dflt = settle_done && std_sel;

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_E1: begin
                if (std_sel) begin
                    next_mode = MODE_SETTLE;
                end
            end
            MODE_SETTLE: begin
                if (!std_sel) begin
                    next_mode = MODE_E1;
                end else if (settle_done) begin
                    next_mode = MODE_T1J1;
                end
            end
            MODE_T1J1: begin
                if (!std_sel) begin
                    next_mode = MODE_E1;
                end
            end
            default: begin
                next_mode = MODE_E1;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            mode <= rst ? MODE_E1 : next_mode;
        end
    end

    tjl_counter #(.W(10)) u_settle (
        .i_clk(I_CLK_SYS),
        .i_ce(I_CE),
        .i_clr(rst || mode != MODE_SETTLE),
        .i_inc(1'b1),
        .o_cnt(settle_cnt)
    );

    // ************************************************************
    // loss-of-signal detection and recovery
    // ************************************************************
    logic [CNT_W-1:0] zero_run, win_cnt, ones_cnt, det_len;
    logic los, dens_bad, win_end, bit0, bit1;
    logic ev_los, ev_rcv, run_ok;

    // threshold in bits: (count + 1) * 16, 0a gives 176
    assign det_len = (CNT_W'(los_det) + CNT_W'(1)) << DET_SHIFT;
    assign bit0 = I_RX_VALID && !I_RX_BIT;
    assign bit1 = I_RX_VALID && I_RX_BIT;
    assign ev_los = !los && bit0 && zero_run == det_len - CNT_W'(1);
    assign win_end = I_RX_VALID && win_cnt == det_len - CNT_W'(1);
    assign run_ok = !(cfg[CFG_PDC] && dens_bad);
    // the one that reaches count + 1 ends the loss, 15 gives 22
    assign ev_rcv = los && bit1 && ones_cnt == CNT_W'(los_rcv)
        && run_ok;

    tjl_counter #(.W(CNT_W)) u_zero_run (
        .i_clk(I_CLK_SYS),
        .i_ce(I_CE),
        .i_clr(rst || cmd_restart || bit1),
        .i_inc(bit0),
        .o_cnt(zero_run)
    );

    tjl_counter #(.W(CNT_W)) u_window (
        .i_clk(I_CLK_SYS),
        .i_ce(I_CE),
        .i_clr(rst || cmd_restart || !los || win_end),
        .i_inc(I_RX_VALID),
        .o_cnt(win_cnt)
    );

    tjl_counter #(.W(CNT_W)) u_ones (
        .i_clk(I_CLK_SYS),
        .i_ce(I_CE),
        .i_clr(rst || cmd_restart || !los || win_end),
        .i_inc(bit1),
        .o_cnt(ones_cnt)
    );

    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (rst || cmd_restart) begin
                los <= 1'b0;
            end else if (ev_los) begin
                los <= 1'b1;
            end else if (ev_rcv) begin
                los <= 1'b0;
            end
        end
    end

    // a 15-zero run spoils the current recovery interval
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (rst || cmd_restart || !los || win_end) begin
                dens_bad <= 1'b0;
            end else if (bit0 && zero_run >= DENS_RUN - CNT_W'(1)) begin
                dens_bad <= 1'b1;
            end
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [IRQ_W-1:0] irq_ev, irq_clr;

    // recovery raises an interrupt only with status-change enabled
    assign irq_ev[IRQ_LOS] = ev_los;
    assign irq_ev[IRQ_RCV] = ev_rcv && cfg[CFG_SCI];
    assign irq_ev[IRQ_SETTLE] = load_dflt;
    assign irq_clr = (I_WR && hit_ist) ? I_WDATA[IRQ_W-1:0] : '0;

    // a new event beats a simultaneous write-one-to-clear
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (rst) begin
                irq_stat <= '0;
            end else begin
                irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            end
        end
    end

    // ************************************************************
    // line coding check
    // ************************************************************
    logic [1:0] code;
    logic code_ok;

    // nrz and precoding exist only on the digital interface
    assign code = cfg[CFG_CODE +: 2];
    assign code_ok = cfg[CFG_DIG]
        ? (!cfg[CFG_PRE] || code == CODE_B8ZS)
        : (code != CODE_NRZ && !cfg[CFG_PRE]);

    // ************************************************************
    // read-back and outputs
    // ************************************************************
    logic [7:0] stat, rd_mux;
    logic t1j1;

    assign t1j1 = mode == MODE_T1J1;
    assign stat = {4'h0, code_ok, t1j1 && cfg[CFG_JPN], t1j1, los};
    // unused and write-only addresses read as zero
    assign rd_mux = hit_cfg ? cfg
        : hit_stat ? stat
        : hit_ist ? 8'(irq_stat)
        : hit_msk ? 8'(irq_mask)
        : hit_det ? los_det
        : hit_rcv ? los_rcv
        : hit_bank ? bank[bank_idx]
        : 8'h00;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (rst) begin
                O_RDATA <= 8'h00;
                O_LOS <= 1'b0;
                O_T1J1_MODE <= 1'b0;
                O_J1_MODE <= 1'b0;
                O_IRQ <= 1'b0;
            end else begin
                O_RDATA <= I_RD ? rd_mux : 8'h00;
                O_LOS <= los;
                O_T1J1_MODE <= t1j1;
                O_J1_MODE <= t1j1 && cfg[CFG_JPN];
                O_IRQ <= |(irq_stat & irq_mask);
            end
        end
    end
endmodule

// ### verif/tjl_line_model.sv
`timescale 1ns/1ns
module tjl_line_model (
    // request from the bench
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [8:0] i_count,
    input wire logic i_value,
    input wire logic i_slow,
    // received line side
    output logic o_valid,
    output logic o_bit,
    output logic o_busy
);
    logic [8:0] left = 9'h000;
    logic gap = 1'b0;
    initial begin
        o_valid = 1'b0;
        o_bit = 1'b0;
        o_busy = 1'b0;
    end
    // between bits the data line toggles, so a stale bit never looks valid
    always @(posedge i_clk) begin
        if (i_go) begin
            left <= i_count;
            o_busy <= 1'b1;
        end else if (left != 9'h000 && !gap) begin
            o_valid <= 1'b1;
            o_bit <= i_value;
            left <= left - 9'h001;
            gap <= i_slow;
        end else begin
            o_valid <= 1'b0;
            o_bit <= ~o_bit;
            gap <= 1'b0;
            o_busy <= left != 9'h000;
        end
    end
endmodule

// ### verif/tjl_config_bank_properties.sv
`timescale 1ns/1ns
module tjl_config_bank_properties
    import tjl_pkg::*;
#(
    parameter int AW = 8
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    // register port
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    // line and status
    input wire logic I_RX_VALID,
    input wire logic I_RX_BIT,
    input wire logic O_LOS,
    input wire logic O_T1J1_MODE,
    input wire logic O_J1_MODE,
    input wire logic O_IRQ
);
    // ************************************************************
    // shadow state
    // ************************************************************
    logic [7:0] det;
    logic [IRQ_W-1:0] msk;
    logic [CNT_W-1:0] zrun;
    logic [10:0] since;
    // outputs carry no value until the qualified reset has run once
    logic armed = 1'b0;
    wire wr_cfg = I_WR && I_ADDR == ADR_CFG;
    wire [CNT_W-1:0] det_len = (CNT_W'(det) + 13'h0001) << DET_SHIFT;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            det <= 8'h00;
            msk <= MASK_RST;
            zrun <= '0;
            since <= '0;
            armed <= 1'b1;
        end else begin
            if (I_WR && I_ADDR == ADR_LOS_DET) det <= I_WDATA;
            if (I_WR && I_ADDR == ADR_IRQ_MASK) msk <= I_WDATA[IRQ_W-1:0];
            if (I_RX_VALID) zrun <= I_RX_BIT ? '0 : zrun + 13'h0001;
            // settle time counts from a mode write made while O_T1J1_MODE is low, in E1 or settling
            if (wr_cfg && !O_T1J1_MODE) since <= '0;
            else if (since != 11'h7ff) since <= since + 11'h001;
        end
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST || !armed);
    // ************************************************************
    // checks
    // ************************************************************
    AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    AST_CMD_WO: assert property (
        I_RD && I_ADDR == ADR_CMD |=> O_RDATA == 8'h00)
        else $error("command register readable");
    AST_J1_IN_T1J1: assert property (O_J1_MODE |-> O_T1J1_MODE)
        else $error("j1 flag outside t1/j1 mode");
    AST_E1_NOW: assert property (
        wr_cfg && !I_WDATA[CFG_STD] |-> ##3 !O_T1J1_MODE)
        else $error("line standard low but not e1");
    AST_SETTLE_TIME: assert property (
        $rose(O_T1J1_MODE) |-> since == 11'(SETTLE_CYC + 2))
        else $error("t1/j1 settle time wrong");
    AST_LOS_DECLARE: assert property (
        I_RX_VALID && !I_RX_BIT && zrun == det_len - 13'h0001 && !O_LOS
        |-> ##2 O_LOS)
        else $error("loss of signal not declared");
    AST_LOS_NOT_EARLY: assert property (
        $rose(O_LOS) |-> $past(zrun) == det_len)
        else $error("loss of signal without full zero run");
    AST_IRQ_MASKED: assert property (msk == 3'h0 |=> !O_IRQ)
        else $error("interrupt with all sources masked");
endmodule
bind tjl_config_bank tjl_config_bank_properties #(.AW(AW)) u_props (
    .I_CLK_SYS, .I_SRST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .I_RX_VALID, .I_RX_BIT, .O_LOS, .O_T1J1_MODE, .O_J1_MODE, .O_IRQ
);

// ### verif/test_tjl_config_bank.sv
`timescale 1ns/1ns
module test_tjl_config_bank import tjl_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [8:0] cnt = 9'h000;
    logic val = 1'b0;
    logic slow = 1'b0;
    logic [7:0] rdata, d;
    logic rx_valid, rx_bit, los, t1j1, j1, irq, busy, jpn, ok;
    logic [7:0] rnd [0:22];
    int mismatches = 0;
    int comparisons = 0;
    always #10 clk = ~clk;
    tjl_config_bank u_dut (.I_CLK_SYS(clk), .I_CE(1'b1), .I_SRST(srst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_RX_VALID(rx_valid), .I_RX_BIT(rx_bit),
        .O_LOS(los), .O_T1J1_MODE(t1j1), .O_J1_MODE(j1), .O_IRQ(irq));
    tjl_line_model u_line (.i_clk(clk), .i_go(go), .i_count(cnt),
        .i_value(val), .i_slow(slow), .o_valid(rx_valid), .o_bit(rx_bit),
        .o_busy(busy));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] bank_exp(input int a);
        return a == 11 ? 8'hfd : (a > 11 && a < 15) ? 8'hff : 8'h00;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
            input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h",
                $time, what, seen, exp);
        end
    endtask
    task automatic hang();
        mismatches++;
        complete_run();
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdd(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk);
    endtask
    task automatic send(input int n, input logic v, input logic s);
        int k = 0;
        go <= 1'b1;
        cnt <= 9'(n);
        val <= v;
        slow <= s;
        @(posedge clk);
        go <= 1'b0;
        #1;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 2000) hang();
        repeat (3) @(posedge clk);
    endtask
    task automatic check_bank();
        for (int a = 8; a < 31; a++) begin
            rdd(8'(a));
            chk(d, bank_exp(a), "bank default");
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int k = 0;
        void'($urandom(32'h44c0));
        @(posedge clk);
        // reset must be qualified over 500 edges before it acts
        srst <= 1'b1;
        repeat (520) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({7'h0, t1j1}, 8'h00, "mode after reset");
        check_bank();
        for (int a = 0; a < 23; a++) begin
            rnd[a] = 8'($urandom);
            wrr(8'(a + 8), rnd[a]);
        end
        for (int a = 0; a < 23; a++) begin
            rdd(8'(a + 8));
            chk(d, rnd[a], "bank readback");
        end
        wrr(8'h1f, 8'h00);
        rdd(8'h1f);
        chk(d, 8'h00, "unused read");
        rdd(ADR_CMD);
        chk(d, 8'h00, "command read");
        for (int i = 0; i < 16; i++) begin
            wrr(ADR_CFG, {i[3], i[2], i[1:0], 4'h0});
            rdd(ADR_STAT);
            // precoding only with b8zs on the digital side
            ok = i[2] ? (!i[3] || i[1:0] == CODE_B8ZS)
                : (!i[3] && i[1:0] != CODE_NRZ);
            chk(d & 8'h08, ok ? 8'h08 : 8'h00, "coding valid");
        end
        jpn = 1'($urandom);
        wrr(ADR_IRQ_MASK, 8'h04);
        wrr(ADR_CFG, {4'h0, 1'b1, 1'b0, jpn, 1'b1});
        while (t1j1 !== 1'b1 && k < 1100) begin
            @(posedge clk);
            k++;
        end
        if (k == 1100) hang();
        @(posedge clk);
        chk({7'h0, j1}, {7'h0, jpn}, "j1 flag");
        chk({7'h0, irq}, 8'h01, "settle irq");
        check_bank();
        wrr(ADR_IRQ_STAT, 8'h04);
        @(posedge clk);
        chk({7'h0, irq}, 8'h00, "irq cleared");
        wrr(ADR_LOS_DET, 8'h0a);
        wrr(ADR_LOS_RCV, 8'h15);
        wrr(ADR_IRQ_MASK, 8'h03);
        send(100, 1'b0, 1'b1);
        send(1, 1'b1, 1'b0);
        send(175, 1'b0, 1'b0);
        chk({7'h0, los}, 8'h00, "broken zero run");
        send(1, 1'b0, 1'b0);
        chk({7'h0, los}, 8'h01, "los after 176 zeros");
        chk({7'h0, irq}, 8'h01, "los irq");
        send(21, 1'b1, 1'b1);
        chk({7'h0, los}, 8'h01, "los after 21 ones");
        send(1, 1'b1, 1'b0);
        chk({7'h0, los}, 8'h00, "los after 22 ones");
        rdd(ADR_IRQ_STAT);
        chk(d, 8'h03, "recovery irq");
        wrr(ADR_IRQ_STAT, 8'h03);
        wrr(ADR_CFG, {4'h0, 1'b1, 1'b1, jpn, 1'b1});
        send(176, 1'b0, 1'b0);
        send(10, 1'b1, 1'b0);
        send(15, 1'b0, 1'b1);
        send(22, 1'b1, 1'b0);
        chk({7'h0, los}, 8'h01, "density check");
        wrr(ADR_CMD, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h0, los}, 8'h00, "los restart");
        send(1, 1'b1, 1'b0);
        // without status-change only the declaration interrupts
        wrr(ADR_CFG, {4'h0, 1'b0, 1'b0, jpn, 1'b1});
        wrr(ADR_IRQ_STAT, 8'h07);
        send(176, 1'b0, 1'b0);
        send(22, 1'b1, 1'b0);
        chk({7'h0, los}, 8'h00, "recovery without status-change");
        rdd(ADR_IRQ_STAT);
        chk(d, 8'h01, "no recovery irq");
        wrr(ADR_CFG, 8'h00);
        repeat (2) @(posedge clk);
        chk({6'h0, j1, t1j1}, 8'h00, "back to e1");
        complete_run();
    end
endmodule
